// ### core/bpr_bus_agent.sv
// bpr_bus_agent: request/response parity generation and checking for one
// system bus agent, plus the exit from system reset.
// assumes bus pins are synchronous to clk_in, that arbitration outside grants
// bus_owner_in, and that a pin wire resolves as wired-low from the enables.
//
// Operation
// - self-test strap at release, float strap clear, runs self-test first
// - fetching always starts at the reset vector
// - float strap keeps every output undriven
// - requester drives parity over strobe and type
// - parity high for even count of lows
// - all lines high gives parity high
// - status lines driven only as response agent
// - response parity driven with status, covers status
// - compatibility reset pin is ignored entirely
// - idle status implies parity seen high
// - owner drives type lines for two clocks
// - system reset releases outputs within one clock
// - straps latched as system reset releases
`timescale 1ns/1ps
module bpr_bus_agent #(
	parameter int SELFTEST_LEN = bpr_pkg::SELFTEST_CYCLES  // self-test length in clocks
) (
	// clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              reset_in,
	// reset pins and straps
	input  wire logic                              sys_reset_n_in,
	input  wire logic                              selftest_req_n_in,
	input  wire logic                              float_cfg_n_in,
	input  wire logic                              unused_compat_pin_in,
	// address strobe pin
	input  wire logic                              address_strobe_n_in,
	output logic                                   address_strobe_n_out,
	output logic                                   address_strobe_n_oe_out,
	// transaction type pins
	input  wire logic [bpr_pkg::REQ_TYPE_W-1:0]    req_type_n_in,
	output logic      [bpr_pkg::REQ_TYPE_W-1:0]    req_type_n_out,
	output logic                                   req_type_n_oe_out,
	// request parity pin
	input  wire logic                              request_parity_n_in,
	output logic                                   request_parity_n_out,
	output logic                                   request_parity_n_oe_out,
	// response status pins
	input  wire logic [bpr_pkg::RSP_STATUS_W-1:0]  response_status_n_in,
	output logic      [bpr_pkg::RSP_STATUS_W-1:0]  response_status_n_out,
	output logic                                   response_status_n_oe_out,
	// response parity pin
	input  wire logic                              response_parity_n_in,
	output logic                                   response_parity_n_out,
	output logic                                   response_parity_n_oe_out,
	// request port from the core
	input  wire logic                              bus_owner_in,
	input  wire logic                              req_valid_in,
	input  wire logic [bpr_pkg::REQ_TYPE_W-1:0]    req_type_a_in,
	input  wire logic [bpr_pkg::REQ_TYPE_W-1:0]    req_type_b_in,
	output logic                                   req_ready_out,
	// response port from the core
	input  wire logic                              rsp_agent_in,
	input  wire logic                              rsp_valid_in,
	input  wire logic [bpr_pkg::RSP_STATUS_W-1:0]  rsp_status_in,
	// reset-exit status
	output logic                                   self_test_run_out,
	output logic                                   fetch_start_out,
	output logic      [bpr_pkg::FETCH_ADDR_W-1:0]  fetch_addr_out,
	output logic                                   float_mode_out,
	// parity errors
	output logic                                   req_parity_err_out,
	output logic                                   rsp_parity_err_out
);

	// reset-exit state
	bpr_pkg::bpr_state_t                 state_ff;       // sequence state
	bpr_pkg::bpr_state_t                 nxt_state;
	logic                                sys_rst_ff;     // system reset seen last cycle
	logic                                selftest_ff;    // strap held while self-test runs
	logic                                float_ff;       // strap held while floated
	logic                                nxt_selftest;
	logic                                nxt_float;
	logic [15:0]                         st_cnt_ff;      // self-test cycle count
	logic [15:0]                         nxt_st_cnt;
	logic                                fetch_ff;       // one-cycle fetch start
	logic [bpr_pkg::FETCH_ADDR_W-1:0]    fetch_addr_ff;  // vector held for the core
	// request drive state
	bpr_pkg::bpr_req_t                   rq_ff;
	bpr_pkg::bpr_req_t                   nxt_rq;
	logic [bpr_pkg::REQ_TYPE_W-1:0]      type_b_ff;      // second type held for phase b
	logic                                ads_n_ff;
	logic [bpr_pkg::REQ_TYPE_W-1:0]      type_n_ff;
	logic                                req_oe_ff;
	logic                                rp_n_ff;
	logic                                nxt_ads_n;
	logic [bpr_pkg::REQ_TYPE_W-1:0]      nxt_type_n;
	logic                                nxt_req_oe;
	logic                                req_ready_ff;
	logic                                as_oe_ff;       // strobe pin driven low
	// response drive state
	logic [bpr_pkg::RSP_STATUS_W-1:0]    rs_n_ff;
	logic                                rsp_oe_ff;
	logic                                rsp_par_ff;
	logic [bpr_pkg::RSP_STATUS_W-1:0]    nxt_rs_n;
	logic                                nxt_rsp_oe;
	// checking
	logic                                ads_seen_ff;    // strobe was low last cycle
	logic                                running;        // first fetch or normal operation
	logic                                sys_rst_act;    // system reset active now
	logic                                release_edge;   // active-to-inactive transition
	logic                                st_done;
	logic                                take_req;
	logic                                req_chk_en;
	logic                                rsp_chk_en;
	// decode of reset pin and state
	assign sys_rst_act  = ~sys_reset_n_in;
	assign release_edge = sys_rst_ff & sys_reset_n_in;
	assign running      = (state_ff == bpr_pkg::ST_RUN) | (state_ff == bpr_pkg::ST_FETCH);
	assign st_done      = (st_cnt_ff == 16'(SELFTEST_LEN - 1));
	// the compatibility reset pin has no load anywhere in this block
	// straps are caught only on the release cycle, otherwise held
	assign nxt_selftest = release_edge ? ~selftest_req_n_in : selftest_ff;
	assign nxt_float    = release_edge ? ~float_cfg_n_in    : float_ff;
	// reset-exit sequence
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_st_cnt = 16'h0000;
		case (state_ff)
			bpr_pkg::ST_HOLD:
			begin
				if (release_edge & ~float_cfg_n_in)
					nxt_state = bpr_pkg::ST_FLOAT;
				else if (release_edge & ~selftest_req_n_in)
					nxt_state = bpr_pkg::ST_SELFTEST;
				else if (release_edge)
					nxt_state = bpr_pkg::ST_FETCH;
			end
			bpr_pkg::ST_SELFTEST:
			begin
				nxt_st_cnt = st_cnt_ff + 16'h0001;
				if (st_done)
					nxt_state = bpr_pkg::ST_FETCH;
			end
			bpr_pkg::ST_FETCH:
				nxt_state = bpr_pkg::ST_RUN;
			bpr_pkg::ST_RUN, bpr_pkg::ST_FLOAT:
				nxt_state = state_ff;
			default:
				nxt_state = bpr_pkg::ST_HOLD;
		endcase
		// system reset overrides every state
		if (sys_rst_act)
			nxt_state = bpr_pkg::ST_HOLD;
	end

	// state, straps and fetch start
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_ff      <= bpr_pkg::ST_HOLD;
			sys_rst_ff    <= 1'b0;
			selftest_ff   <= 1'b0;
			float_ff      <= 1'b0;
			st_cnt_ff     <= 16'h0000;
			fetch_ff      <= 1'b0;
			fetch_addr_ff <= '0;
		end
		else
		begin
			state_ff      <= nxt_state;
			sys_rst_ff    <= sys_rst_act;
			selftest_ff   <= nxt_selftest & (nxt_state == bpr_pkg::ST_SELFTEST);
			float_ff      <= nxt_float & (nxt_state == bpr_pkg::ST_FLOAT);
			st_cnt_ff     <= nxt_st_cnt;
			fetch_ff      <= (nxt_state == bpr_pkg::ST_FETCH);
			fetch_addr_ff <= bpr_pkg::RESET_VECTOR;
		end
	end

	// request sequencing: strobe on the first clock, type for two clocks
	assign take_req = req_ready_ff & req_valid_in & bus_owner_in;
	always_comb
	begin
		nxt_rq     = bpr_pkg::RQ_IDLE;
		nxt_ads_n  = 1'b1;
		nxt_type_n = bpr_pkg::REQ_TYPE_IDLE;
		nxt_req_oe = 1'b0;
		case (rq_ff)
			bpr_pkg::RQ_IDLE:
			begin
				if (take_req)
				begin
					nxt_rq     = bpr_pkg::RQ_A;
					nxt_ads_n  = 1'b0;
					nxt_type_n = ~req_type_a_in;
					nxt_req_oe = 1'b1;
				end
			end
			bpr_pkg::RQ_A:
			begin
				nxt_rq     = bpr_pkg::RQ_B;
				nxt_type_n = ~type_b_ff;
				nxt_req_oe = 1'b1;
			end
			default:
				nxt_rq = bpr_pkg::RQ_IDLE;  // phase b ends the request
		endcase
		// reset or float drops the drive at once, cutting a request short
		if (sys_rst_act | ~running)
		begin
			nxt_rq     = bpr_pkg::RQ_IDLE;
			nxt_ads_n  = 1'b1;
			nxt_type_n = bpr_pkg::REQ_TYPE_IDLE;
			nxt_req_oe = 1'b0;
		end
	end

	// response drive: status and parity for one clock, only as response agent
	assign nxt_rsp_oe = rsp_valid_in & rsp_agent_in & running & ~sys_rst_act;
	assign nxt_rs_n   = nxt_rsp_oe ? ~rsp_status_in : bpr_pkg::RSP_STATUS_IDLE;

	// pin registers; parity is taken from the same next values it covers
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			rq_ff        <= bpr_pkg::RQ_IDLE;
			type_b_ff    <= '0;
			ads_n_ff     <= 1'b1;
			type_n_ff    <= bpr_pkg::REQ_TYPE_IDLE;
			req_oe_ff    <= 1'b0;
			rp_n_ff      <= 1'b1;
			req_ready_ff <= 1'b0;
			as_oe_ff     <= 1'b0;
			rs_n_ff      <= bpr_pkg::RSP_STATUS_IDLE;
			rsp_oe_ff    <= 1'b0;
			rsp_par_ff   <= 1'b1;
			ads_seen_ff  <= 1'b0;
		end
		else
		begin
			rq_ff        <= nxt_rq;
			type_b_ff    <= take_req ? req_type_b_in : type_b_ff;
			ads_n_ff     <= nxt_ads_n;
			type_n_ff    <= nxt_type_n;
			req_oe_ff    <= nxt_req_oe;
			rp_n_ff      <= bpr_pkg::bpr_parity({2'b11, nxt_ads_n, nxt_type_n});
			req_ready_ff <= (nxt_rq == bpr_pkg::RQ_IDLE) & (nxt_state == bpr_pkg::ST_RUN);
			as_oe_ff     <= nxt_req_oe & ~nxt_ads_n;
			rs_n_ff      <= nxt_rs_n;
			rsp_oe_ff    <= nxt_rsp_oe;
			rsp_par_ff   <= bpr_pkg::bpr_parity({5'h1f, nxt_rs_n});
			ads_seen_ff  <= ~address_strobe_n_in;
		end
	end

	// request parity is valid on the strobe clock and the one after it;
	// response parity is checked every clock of ST_RUN since idle lines carry good parity
	assign req_chk_en = (state_ff == bpr_pkg::ST_RUN) & (~address_strobe_n_in | ads_seen_ff);
	assign rsp_chk_en = (state_ff == bpr_pkg::ST_RUN);
	// request parity check over strobe and all type lines
	bpr_par_check #(.W (bpr_pkg::REQ_TYPE_W + 1)) u_req_chk (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.check_en_in (req_chk_en),
		.sig_n_in    ({address_strobe_n_in, req_type_n_in}),
		.par_n_in    (request_parity_n_in),
		.err_out     (req_parity_err_out)
	);

	// response parity check over the status lines
	bpr_par_check #(.W (bpr_pkg::RSP_STATUS_W)) u_rsp_chk (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.check_en_in (rsp_chk_en),
		.sig_n_in    (response_status_n_in),
		.par_n_in    (response_parity_n_in),
		.err_out     (rsp_parity_err_out)
	);

	// outputs, all from registers
	assign address_strobe_n_out     = ads_n_ff;
	assign address_strobe_n_oe_out  = as_oe_ff;
	assign req_type_n_out           = type_n_ff;
	assign req_type_n_oe_out        = req_oe_ff;
	assign request_parity_n_out     = rp_n_ff;
	assign request_parity_n_oe_out  = req_oe_ff;
	assign response_status_n_out    = rs_n_ff;
	assign response_status_n_oe_out = rsp_oe_ff;
	assign response_parity_n_out    = rsp_par_ff;
	assign response_parity_n_oe_out = rsp_oe_ff;
	assign req_ready_out            = req_ready_ff;
	assign self_test_run_out        = selftest_ff;
	assign fetch_start_out          = fetch_ff;
	assign fetch_addr_out           = fetch_addr_ff;
	assign float_mode_out           = float_ff;

endmodule : bpr_bus_agent

// ### core/bpr_pkg.sv
// bpr_pkg: constants, state types and the parity function shared by the
// bus parity and reset-exit logic.
// assumes one bus clock; all bus pins are active low and pulled high when idle.
package bpr_pkg;

	// bus widths
	localparam int          REQ_TYPE_W      = 5;              // transaction type lines
	localparam int          RSP_STATUS_W    = 3;              // response status lines
	localparam int          FETCH_ADDR_W    = 32;             // power-on vector width

	// values after reset exit
	localparam logic [31:0] RESET_VECTOR    = 32'h0fff_fff0;  // first fetch address
	localparam logic [4:0]  REQ_TYPE_IDLE   = 5'h1f;          // type lines released
	localparam logic [2:0]  RSP_STATUS_IDLE = 3'h7;           // status lines released

	// counts of cycles
	localparam int          SELFTEST_CYCLES = 64;             // default self-test length
	localparam int          REQ_PHASES      = 2;              // clocks a type is driven

	// reset-exit sequence
	typedef enum logic [2:0] {
		ST_HOLD,      // system reset active, outputs released
		ST_SELFTEST,  // built-in self-test running
		ST_FETCH,     // issue first fetch at the vector
		ST_RUN,       // normal operation
		ST_FLOAT      // outputs held in high impedance by strap
	} bpr_state_t;

	// request drive phases
	typedef enum logic [1:0] {
		RQ_IDLE,      // not driving a request
		RQ_A,         // first clock: strobe plus first type
		RQ_B          // second clock: second type
	} bpr_req_t;

	// parity over up to eight active-low lines; unused upper bits are passed
	// as ones so they add no low line. high when the count of lows is even.
	function automatic logic bpr_parity(input logic [7:0] sig_n);
		bpr_parity = ~(^(~sig_n));
	endfunction : bpr_parity

endpackage : bpr_pkg

// ### core/bpr_par_check.sv
// bpr_par_check: recomputes parity over received active-low lines and flags
// a one-cycle error when the received parity line disagrees.
// assumes the lines are synchronous to clk_in and at most eight wide.
`timescale 1ns/1ps
module bpr_par_check #(
	parameter int W = 3                         // covered lines
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// sampled bus lines
	input  wire logic         check_en_in,     // lines are valid this cycle
	input  wire logic [W-1:0] sig_n_in,        // covered lines
	input  wire logic         par_n_in,        // received parity line
	// result
	output logic              err_out          // one-cycle parity error
);

	logic       err_ff;                         // registered mismatch
	logic       nxt_err;                        // mismatch this cycle
	logic [7:0] padded_n;                       // lines padded with ones
	logic       expect_par;                     // parity the lines imply

	// padding with ones leaves the count of low lines unchanged
	assign padded_n   = {{(8 - W){1'b1}}, sig_n_in};
	assign expect_par = bpr_pkg::bpr_parity(padded_n);
	assign nxt_err    = check_en_in & (expect_par != par_n_in);
	assign err_out    = err_ff;

	// error flag lasts one cycle per bad sample
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			err_ff <= 1'b0;
		else
			err_ff <= nxt_err;
	end

endmodule : bpr_par_check

// ### test/bpr_bus_agent_checker.sv
// bpr_bus_agent_checker: timing and parity properties on the bus agent's ports.
// assumes one clock domain; bound to every bpr_bus_agent below its endmodule.
`timescale 1ns/1ps
module bpr_bus_agent_checker #(
	parameter int SELFTEST_LEN = 64  // self-test length handed on by the bind
) (
	// clock, reset and straps
	input wire logic       clk_in, reset_in, sys_reset_n_in, selftest_req_n_in, float_cfg_n_in,
	// request pins and port
	input wire logic       address_strobe_n_in, address_strobe_n_out, address_strobe_n_oe_out,
	input wire logic [4:0] req_type_n_in, req_type_n_out, req_type_a_in, req_type_b_in,
	input wire logic       req_type_n_oe_out, request_parity_n_in, request_parity_n_out,
	input wire logic       request_parity_n_oe_out, bus_owner_in, req_valid_in, req_ready_out,
	// response pins and port
	input wire logic [2:0] response_status_n_in, response_status_n_out, rsp_status_in,
	input wire logic       response_status_n_oe_out, response_parity_n_in,
	input wire logic       response_parity_n_out, response_parity_n_oe_out,
	input wire logic       rsp_agent_in, rsp_valid_in,
	// reset-exit status and errors
	input wire logic       self_test_run_out, fetch_start_out, float_mode_out,
	input wire logic [31:0] fetch_addr_out,
	input wire logic       req_parity_err_out, rsp_parity_err_out
);
	logic       run_ff;     // normal operation, seen from the outside
	logic [7:0] st_cnt_ff;  // clocks of the current self-test
	wire        any_oe = address_strobe_n_oe_out | req_type_n_oe_out | request_parity_n_oe_out
		| response_status_n_oe_out | response_parity_n_oe_out;
	wire        strobe_w = address_strobe_n_oe_out ? address_strobe_n_out : 1'b1;
	// run starts after the first fetch and ends with system reset
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			run_ff    <= 1'b0;
			st_cnt_ff <= 8'h00;
		end
		else
		begin
			run_ff    <= sys_reset_n_in & (run_ff | fetch_start_out);
			st_cnt_ff <= self_test_run_out ? st_cnt_ff + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_rel; sys_reset_n_in && !$past(sys_reset_n_in); endsequence
	sequence s_take; req_ready_out && req_valid_in && bus_owner_in; endsequence
	sequence s_req_drive;
		address_strobe_n_oe_out && !address_strobe_n_out && req_type_n_oe_out
		&& req_type_n_out == ~$past(req_type_a_in) ##1 !address_strobe_n_oe_out
		&& req_type_n_oe_out && req_type_n_out == ~$past(req_type_b_in, 2);
	endsequence
	property p_req_phase; s_take |=> s_req_drive; endproperty
	a_req_phase: assert property (p_req_phase) else $error("request phase wrong");
	property p_req_par; request_parity_n_oe_out
		|-> request_parity_n_out == ~^(~{strobe_w, req_type_n_out}); endproperty
	a_req_par: assert property (p_req_par) else $error("request parity wrong");
	property p_req_idle; !request_parity_n_oe_out
		|-> request_parity_n_out && req_type_n_out == 5'h1f; endproperty
	a_req_idle: assert property (p_req_idle) else $error("idle parity low");
	property p_rsp_drive; (run_ff | fetch_start_out) && sys_reset_n_in && rsp_valid_in
		&& rsp_agent_in |=> response_status_n_oe_out && response_parity_n_oe_out
		&& response_status_n_out == ~$past(rsp_status_in); endproperty
	a_rsp_drive: assert property (p_rsp_drive) else $error("response not driven");
	property p_rsp_agent; response_status_n_oe_out |-> $past(rsp_valid_in && rsp_agent_in);
	endproperty
	a_rsp_agent: assert property (p_rsp_agent) else $error("status driven unasked");
	property p_rsp_par; response_parity_n_oe_out |-> response_status_n_oe_out
		&& response_parity_n_out == ~^(~response_status_n_out); endproperty
	a_rsp_par: assert property (p_rsp_par) else $error("response parity wrong");
	property p_rsp_idle; !response_status_n_oe_out
		|-> response_parity_n_out && response_status_n_out == 3'h7; endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("idle status wrong");
	property p_sysrst; !sys_reset_n_in |=> !any_oe && !req_ready_out; endproperty
	a_sysrst: assert property (p_sysrst) else $error("outputs kept in reset");
	property p_float; s_rel ##0 !float_cfg_n_in |=> float_mode_out [*3]; endproperty
	a_float: assert property (p_float) else $error("float strap lost");
	property p_floated; float_mode_out |-> !any_oe && !fetch_start_out; endproperty
	a_floated: assert property (p_floated) else $error("floated output drives");
	property p_st_start; s_rel ##0 float_cfg_n_in && !selftest_req_n_in
		|=> self_test_run_out && !fetch_start_out; endproperty
	a_st_start: assert property (p_st_start) else $error("self-test missing");
	property p_st_len; $fell(self_test_run_out) |-> st_cnt_ff == SELFTEST_LEN && fetch_start_out;
	endproperty
	a_st_len: assert property (p_st_len) else $error("self-test length wrong");
	property p_fetch; fetch_start_out
		|-> fetch_addr_out == bpr_pkg::RESET_VECTOR ##1 req_ready_out; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch start wrong");
	property p_req_err; run_ff && sys_reset_n_in && !address_strobe_n_in && request_parity_n_in
		!= ~^(~{address_strobe_n_in, req_type_n_in}) |=> req_parity_err_out; endproperty
	a_req_err: assert property (p_req_err) else $error("request error missed");
	property p_rsp_err; run_ff && sys_reset_n_in
		&& response_parity_n_in != ~^(~response_status_n_in) |=> rsp_parity_err_out; endproperty
	a_rsp_err: assert property (p_rsp_err) else $error("response error missed");
endmodule : bpr_bus_agent_checker
bind bpr_bus_agent bpr_bus_agent_checker #(.SELFTEST_LEN(SELFTEST_LEN)) u_chk (.*);

// ### test/bpr_far_agent.sv
// bpr_far_agent: another agent on the shared bus, issuing requests and responses.
// assumes the bench resolves each pin wired-low with pull-ups when oe is low.
`timescale 1ns/1ps
module bpr_far_agent (
	// clock and system reset
	input  wire logic       clk_in,
	input  wire logic       sys_reset_n_in,
	// request pins
	output logic            strobe_n_out,
	output logic [4:0]      type_n_out,
	output logic            rp_n_out,
	output logic            req_oe_out,
	// response pins
	output logic [2:0]      status_n_out,
	output logic            rsp_par_n_out,
	output logic            rsp_oe_out
);
	// parity high when the count of low lines is even
	function automatic logic par6(input logic [5:0] v);
		par6 = ($countones(~v) % 2) == 0;
	endfunction : par6
	// everything released; callers never start while system reset is low
	initial
	begin
		{strobe_n_out, type_n_out, rp_n_out, req_oe_out} = 8'hfe;
		{status_n_out, rsp_par_n_out, rsp_oe_out} = 5'h1e;
	end
	// two type clocks after an optional wait; bad spoils the first parity
	task automatic send_req(input int gap, input logic [4:0] a, b, input logic bad);
		repeat (gap) @(posedge clk_in);
		if (gap > 0) #1;
		{req_oe_out, strobe_n_out, type_n_out} = {2'b10, ~a};
		rp_n_out = par6({1'b0, ~a}) ^ bad;
		@(posedge clk_in);
		#1 {strobe_n_out, type_n_out} = {1'b1, ~b};
		rp_n_out = par6({1'b1, ~b});
		@(posedge clk_in);
		#1 {strobe_n_out, type_n_out, rp_n_out, req_oe_out} = 8'hfe;
	endtask : send_req
	// one clock of status with its parity; released lines read 111 and high
	task automatic send_rsp(input int gap, input logic [2:0] s, input logic bad);
		repeat (gap) @(posedge clk_in);
		if (gap > 0) #1;
		{status_n_out, rsp_oe_out} = {~s, 1'b1};
		rsp_par_n_out = par6({3'h7, ~s}) ^ bad;
		@(posedge clk_in);
		#1 {status_n_out, rsp_par_n_out, rsp_oe_out} = 5'h1e;
	endtask : send_rsp
endmodule : bpr_far_agent

// ### test/bpr_bus_agent_tb_top.sv
// bpr_bus_agent_tb_top: self-checking bench, one agent facing a far agent model.
// assumes the checker is bound from its own file; pins resolve wired-low.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bpr_bus_agent_tb_top;
	localparam int ST_LEN = 4;  // short self-test keeps the run brief
	logic clk_in = 0, reset_in = 1, sys_n = 0, st_n = 1, fl_n = 1, compat = 0;
	logic owner = 1, rv = 0, agent = 0, rsv = 0;
	logic [4:0] tya = 0, tyb = 0, ty_o, f_ty;
	logic [2:0] rs = 0, rs_o, f_rs;
	logic [31:0] faddr;
	logic as_o, as_oe, ty_oe, rp_o, rp_oe, rs_oe, rsp_o, rsp_oe, ready, st_run, fetch, flt;
	logic rq_err, rs_err, f_as, f_rp, f_qoe, f_rsp, f_soe;
	logic [33:0] exp_q[$];  // oldest expected result first
	int fails = 0, check_count = 0;
	// each pin is low if any enabled driver pulls it low
	wire       w_as  = (as_oe ? as_o : 1'b1) & (f_qoe ? f_as : 1'b1);
	wire [4:0] w_ty  = (ty_oe ? ty_o : 5'h1f) & (f_qoe ? f_ty : 5'h1f);
	wire       w_rp  = (rp_oe ? rp_o : 1'b1) & (f_qoe ? f_rp : 1'b1);
	wire [2:0] w_rs  = (rs_oe ? rs_o : 3'h7) & (f_soe ? f_rs : 3'h7);
	wire       w_rsp = (rsp_oe ? rsp_o : 1'b1) & (f_soe ? f_rsp : 1'b1);
	always #2 clk_in = ~clk_in;
	bpr_bus_agent #(.SELFTEST_LEN(ST_LEN)) DUT (.clk_in(clk_in), .reset_in(reset_in),
		.sys_reset_n_in(sys_n), .selftest_req_n_in(st_n), .float_cfg_n_in(fl_n),
		.unused_compat_pin_in(compat), .address_strobe_n_in(w_as), .address_strobe_n_out(as_o),
		.address_strobe_n_oe_out(as_oe), .req_type_n_in(w_ty), .req_type_n_out(ty_o),
		.req_type_n_oe_out(ty_oe), .request_parity_n_in(w_rp), .request_parity_n_out(rp_o),
		.request_parity_n_oe_out(rp_oe), .response_status_n_in(w_rs),
		.response_status_n_out(rs_o), .response_status_n_oe_out(rs_oe),
		.response_parity_n_in(w_rsp), .response_parity_n_out(rsp_o),
		.response_parity_n_oe_out(rsp_oe), .bus_owner_in(owner), .req_valid_in(rv),
		.req_type_a_in(tya), .req_type_b_in(tyb), .req_ready_out(ready), .rsp_agent_in(agent),
		.rsp_valid_in(rsv), .rsp_status_in(rs), .self_test_run_out(st_run),
		.fetch_start_out(fetch), .fetch_addr_out(faddr), .float_mode_out(flt),
		.req_parity_err_out(rq_err), .rsp_parity_err_out(rs_err));
	bpr_far_agent far (.clk_in(clk_in), .sys_reset_n_in(sys_n), .strobe_n_out(f_as),
		.type_n_out(f_ty), .rp_n_out(f_rp), .req_oe_out(f_qoe), .status_n_out(f_rs),
		.rsp_par_n_out(f_rsp), .rsp_oe_out(f_soe));
	function automatic logic par(input logic [5:0] v);
		par = ($countones(~v) % 2) == 0;
	endfunction : par
	// compare one seen result with the oldest note; nothing noted reads as x
	task automatic chk_next(input logic [33:0] g);
		logic [33:0] e;
		e = exp_q.size() ? exp_q.pop_front() : 'x;
		`CHK(g, e)
	endtask : chk_next
	// the compatibility pin wanders all run long and must change nothing
	always @(posedge clk_in) #1 compat = 1'($urandom);
	always @(posedge clk_in)
	begin
		#1;
		if (fetch) chk_next({2'b00, faddr});
		if (ty_oe) chk_next({2'b01, 25'h0, rp_o, as_oe ? as_o : 1'b1, ty_o});
		if (rs_oe) chk_next({2'b10, 28'h0, rsp_o, rs_o});
		if (rq_err) chk_next({2'b11, 32'h1});
		if (rs_err) chk_next({2'b11, 32'h2});
	end
	// system reset pulse with the straps set only around its release
	task automatic restart(input logic fl, input logic st);
		sys_n = 1'b0;
		repeat (2) @(posedge clk_in);
		#1 {fl_n, st_n, sys_n} = {fl, st, 1'b1};
		@(posedge clk_in);
		#1 {fl_n, st_n} = 2'b11;
	endtask : restart
	// hold a request until ready, note both type clocks before the taking edge
	task automatic req(input logic [4:0] a, b);
		{rv, tya, tyb} = {1'b1, a, b};
		for (int n = 0; n < 50 && ready !== 1'b1; n++) begin @(posedge clk_in); #1; end
		exp_q.push_back({2'b01, 25'h0, par({1'b0, ~a}), 1'b0, ~a});
		exp_q.push_back({2'b01, 25'h0, par({1'b1, ~b}), 1'b1, ~b});
		@(posedge clk_in);
		#1;
	endtask : req
	// one response clock; noted only when this agent answers
	task automatic rsp(input logic [2:0] s, input logic ag);
		{rsv, agent, rs} = {1'b1, ag, s};
		if (ag) exp_q.push_back({2'b10, 28'h0, par({3'h7, ~s}), ~s});
		@(posedge clk_in);
		#1;
	endtask : rsp
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		#80000;
		fails++;
		test_done();
	end
	initial
	begin
		void'($urandom(35));
		repeat (4) @(posedge clk_in);
		#1 reset_in = 1'b0;
		rv = 1'b1;
		restart(1'b0, 1'b1);
		repeat (4) @(posedge clk_in);
		#1 `CHK({flt, as_oe, ty_oe, rs_oe, fetch, ready}, 6'h20)
		rv = 1'b0;
		exp_q.push_back({2'b00, bpr_pkg::RESET_VECTOR});
		restart(1'b1, 1'b0);
		@(posedge clk_in);
		#1 `CHK(st_run, 1'b1)
		for (int i = 0; i < 32; i++) req(i[4:0], 5'($urandom));
		// request held without bus ownership must never be taken
		owner = 1'b0;
		repeat (4) @(posedge clk_in);
		#1 {rv, owner} = 2'b01;
		repeat (4) @(posedge clk_in);
		#1 rv = 1'b0;
		for (int i = 0; i < 8; i++) rsp(i[2:0], 1'b1);
		rsp(3'($urandom), 1'b0);
		rsv = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (i[0]) exp_q.push_back({2'b11, 32'h1});
			far.send_req(i, 5'($urandom), 5'($urandom), i[0]);
			if (i[1]) exp_q.push_back({2'b11, 32'h2});
			far.send_rsp(i, 3'($urandom), i[1]);
		end
		rsp(3'h5, 1'b1);
		sys_n = 1'b0;
		repeat (2) @(posedge clk_in);
		#1 `CHK({ready, as_oe, ty_oe, rp_oe, rs_oe, rsp_oe}, 6'h00)
		rsv = 1'b0;
		exp_q.push_back({2'b00, bpr_pkg::RESET_VECTOR});
		restart(1'b1, 1'b1);
		repeat (4) @(posedge clk_in);
		#1 `CHK(exp_q.size(), 0)
		test_done();
	end
endmodule : bpr_bus_agent_tb_top
